// File: pkg/iosd_pkg.sv
// I/O space decode package: access kinds, request carrier, address map,
// extended register table and field masks.
// Assumes one system clock shared with the CPU core.
package iosd_pkg;

	// Direct, indirect and displaced data-space accesses share one op
	typedef enum logic [2:0] {
		OP_IN,
		OP_OUT,
		OP_SET_IO_BIT,
		OP_CLR_IO_BIT,
		OP_DATA_LOAD,
		OP_DATA_STORE
	} iosd_op_t;

	typedef struct packed {
		logic valid;
		iosd_op_t op;
		logic [7:0] addr;
		logic [2:0] bit_idx;
		logic [7:0] wdata;
	} iosd_req_t;

	localparam int IO_DEPTH = 64;
	localparam int N_EXT = 10;
	localparam logic [7:0] IO_SPACE_OFFSET = 8'h20;
	localparam logic [7:0] BIT_OP_MAX = 8'h1f;
	localparam logic [7:0] IO_DATA_TOP = 8'h5f;
	localparam logic [7:0] EXT_DATA_LO = 8'h60;
	localparam logic [5:0] FLAG_IO_ADDR = 6'h1c;
	localparam logic [7:0] IO_RESET = 8'h00;

	// Extended register table, index N_EXT-1 first, index 0 last
	localparam int EXT_SHIFT_STATUS = 2;
	localparam int EXT_UART_A = 4;
	localparam logic [N_EXT-1:0][7:0] EXT_ADDR = {
		8'hc6, 8'hc5, 8'hc4, 8'hc2, 8'hc1, 8'hc0, 8'hba, 8'hb9, 8'hb8, 8'hb6};
	localparam logic [N_EXT-1:0][7:0] EXT_WMASK = {
		8'hff, 8'h0f, 8'hff, 8'h7f, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h1f};
	localparam logic [N_EXT-1:0][7:0] EXT_W1C = {
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h40, 8'h00, 8'he0, 8'h00, 8'h00};
	localparam logic [N_EXT-1:0][7:0] EXT_RESET = '0;

endpackage

// File: core/iosd_decode.sv
// I/O space address decoder and register bank for the CPU core.
// Assumes requests come from core logic on sys_clk, one per cycle.
//
// Function
// R1: Software writes zero to reserved bits.
// R2: Software never writes reserved I/O locations.
// R3: Writing one clears status flag; zero keeps.
// R4: Bit set/clear changes only addressed bit.
// R5: Bit set/clear reaches I/O 0x00-0x1F only.
// R6: In/out use I/O addresses 0x00-0x3F.
// R7: Data-space address is I/O address plus 0x20.
// R8: Extended 0x60-0xFF reachable only by data access.
// R9: Reserved writes ignored, reserved reads return zero.
`timescale 1ns/10ps
module iosd_decode
	import iosd_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// Request from the core
	input wire iosd_req_t req,
	// Hardware flag set events
	input wire logic [7:0] low_flag_set,
	input wire logic [N_EXT-1:0][7:0] ext_flag_set,
	// Answers
	output logic [7:0] rd_data_ff,
	output logic rd_valid_ff,
	output logic refuse_ff,
	// Register contents for the peripherals
	output logic [7:0] low_flags_ff,
	output logic [N_EXT-1:0][7:0] ext_regs_ff
);

	logic [7:0] io_mem_ff [IO_DEPTH];
	logic [7:0] nxt_io_mem [IO_DEPTH];
	logic [N_EXT-1:0][7:0] nxt_ext_regs;
	logic [7:0] nxt_rd_data;
	logic nxt_rd_valid;
	logic nxt_refuse;
	logic [7:0] nxt_low_flags;
	logic [7:0] data_addr;
	logic [5:0] io_idx;
	logic [3:0] ext_idx;
	logic is_io;
	logic ext_hit;
	logic is_bit;
	logic bit_legal;
	logic is_write;
	logic [7:0] old_val;
	logic [7:0] wmask;
	logic [7:0] w1c;
	logic [7:0] onehot;
	logic [7:0] rw_val;
	logic [7:0] clr_val;
	logic [7:0] new_val;

	always_comb begin
		nxt_io_mem = io_mem_ff;
		nxt_ext_regs = ext_regs_ff;
		is_bit = (req.op == OP_SET_IO_BIT) || (req.op == OP_CLR_IO_BIT);
		bit_legal = req.addr <= BIT_OP_MAX; // R5
		case (req.op)
			OP_IN, OP_OUT: begin
				data_addr = {2'b00, req.addr[5:0]} + IO_SPACE_OFFSET; // R6 R8
			end
			OP_SET_IO_BIT, OP_CLR_IO_BIT: begin
				data_addr = {3'b000, req.addr[4:0]} + IO_SPACE_OFFSET; // R5
			end
			default: begin
				data_addr = req.addr; // R7
			end
		endcase
		is_io = (data_addr >= IO_SPACE_OFFSET) && (data_addr <= IO_DATA_TOP); // R7
		io_idx = 6'(data_addr - IO_SPACE_OFFSET);
		ext_hit = 1'b0;
		ext_idx = 4'h0;
		for (int i = 0; i < N_EXT; i++) begin
			if (data_addr == EXT_ADDR[i]) begin
				ext_hit = 1'b1;
				ext_idx = 4'(i);
			end
		end
		if (is_io) begin
			old_val = io_mem_ff[io_idx];
			wmask = 8'hff;
			w1c = (io_idx == FLAG_IO_ADDR) ? 8'hff : 8'h00;
		end else if (ext_hit) begin
			old_val = ext_regs_ff[ext_idx];
			wmask = EXT_WMASK[ext_idx];
			w1c = EXT_W1C[ext_idx];
		end else begin
			old_val = 8'h00; // R9
			wmask = 8'h00;
			w1c = 8'h00;
		end
		onehot = 8'h01 << req.bit_idx;
		if (is_bit) begin
			// Only the addressed bit sees a write; a set on a flag clears it alone
			rw_val = (req.op == OP_SET_IO_BIT) ? (old_val | onehot) : (old_val & ~onehot); // R4
			clr_val = (req.op == OP_SET_IO_BIT) ? onehot : 8'h00; // R4
		end else begin
			rw_val = req.wdata;
			clr_val = req.wdata;
		end
		new_val = (rw_val & wmask & ~w1c) | (old_val & w1c & ~clr_val); // R3
		is_write = req.valid && ((req.op == OP_OUT) || (req.op == OP_DATA_STORE) || (is_bit && bit_legal));
		if (is_write && is_io) begin
			nxt_io_mem[io_idx] = new_val;
		end else if (is_write && ext_hit && !is_bit) begin
			nxt_ext_regs[ext_idx] = new_val; // R8
		end
		// Hardware set is applied last so it wins over a same-cycle clear
		nxt_io_mem[FLAG_IO_ADDR] = nxt_io_mem[FLAG_IO_ADDR] | low_flag_set;
		for (int i = 0; i < N_EXT; i++) begin
			nxt_ext_regs[i] = nxt_ext_regs[i] | (ext_flag_set[i] & EXT_W1C[i]);
		end
		nxt_low_flags = nxt_io_mem[FLAG_IO_ADDR];
		nxt_rd_valid = req.valid && ((req.op == OP_IN) || (req.op == OP_DATA_LOAD));
		nxt_rd_data = nxt_rd_valid ? old_val : 8'h00; // R9
		nxt_refuse = req.valid && ((is_bit && !bit_legal) ||
			(is_write && !is_io && !ext_hit)); // R5 R9
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < IO_DEPTH; i++) begin
				io_mem_ff[i] <= IO_RESET;
			end
			ext_regs_ff <= EXT_RESET;
			low_flags_ff <= IO_RESET;
			rd_data_ff <= 8'h00;
			rd_valid_ff <= 1'b0;
			refuse_ff <= 1'b0;
		end else begin
			io_mem_ff <= nxt_io_mem;
			ext_regs_ff <= nxt_ext_regs;
			low_flags_ff <= nxt_low_flags;
			rd_data_ff <= nxt_rd_data;
			rd_valid_ff <= nxt_rd_valid;
			refuse_ff <= nxt_refuse;
		end
	end

	// Checks
	localparam logic [7:0] RSV_ADDR = 8'hc3;
	localparam logic [7:0] FLAG_DATA_ADDR = {2'b00, FLAG_IO_ADDR} + IO_SPACE_OFFSET;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_b);

	sequence s_status_store;
		req.valid && req.op == OP_DATA_STORE && req.addr == EXT_ADDR[EXT_SHIFT_STATUS]
			&& ext_flag_set[EXT_SHIFT_STATUS] == 8'h00;
	endsequence

	property p_w1c_one_clears;
		s_status_store ##0 req.wdata[7] |=> ext_regs_ff[EXT_SHIFT_STATUS][7] == 1'b0;
	endproperty
	a_w1c_one_clears: assert property (p_w1c_one_clears) else $error("flag not cleared by one"); // R3

	property p_w1c_zero_keeps;
		s_status_store ##0 !req.wdata[7] |=> $stable(ext_regs_ff[EXT_SHIFT_STATUS][7]);
	endproperty
	a_w1c_zero_keeps: assert property (p_w1c_zero_keeps) else $error("flag changed by zero"); // R3

	sequence s_flag_bit_op;
		req.valid && (req.op == OP_SET_IO_BIT || req.op == OP_CLR_IO_BIT)
			&& req.addr == {2'b00, FLAG_IO_ADDR} && low_flag_set == 8'h00;
	endsequence

	property p_bit_only;
		s_flag_bit_op |=> (low_flags_ff & ~(8'h01 << $past(req.bit_idx)))
			== ($past(low_flags_ff) & ~(8'h01 << $past(req.bit_idx)));
	endproperty
	a_bit_only: assert property (p_bit_only) else $error("bit op touched other bits"); // R4

	property p_bit_range;
		req.valid && (req.op == OP_SET_IO_BIT || req.op == OP_CLR_IO_BIT) && req.addr > BIT_OP_MAX
			&& low_flag_set == 8'h00 |=> refuse_ff && $stable(low_flags_ff);
	endproperty
	a_bit_range: assert property (p_bit_range) else $error("bit op above range accepted"); // R5

	property p_in_read;
		req.valid && req.op == OP_IN && req.addr[5:0] == FLAG_IO_ADDR
			|=> rd_valid_ff && rd_data_ff == $past(low_flags_ff);
	endproperty
	a_in_read: assert property (p_in_read) else $error("in read wrong data"); // R6

	property p_data_offset;
		req.valid && req.op == OP_DATA_LOAD && req.addr == FLAG_DATA_ADDR
			|=> rd_valid_ff && rd_data_ff == $past(low_flags_ff);
	endproperty
	a_data_offset: assert property (p_data_offset) else $error("data offset mismatch"); // R7

	property p_out_no_ext;
		req.valid && req.op == OP_OUT && ext_flag_set == '0 |=> ext_regs_ff == $past(ext_regs_ff);
	endproperty
	a_out_no_ext: assert property (p_out_no_ext) else $error("out reached extended space"); // R8

	property p_reserved;
		req.valid && req.addr == RSV_ADDR && (req.op == OP_DATA_LOAD || req.op == OP_DATA_STORE)
			&& ext_flag_set == '0
			|=> (rd_valid_ff ? rd_data_ff == 8'h00 : refuse_ff) && ext_regs_ff == $past(ext_regs_ff);
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved access misbehaved"); // R9

	// A hardware set must survive any same-cycle clear
	property p_set_wins;
		low_flag_set != 8'h00 |=> (low_flags_ff & $past(low_flag_set)) == $past(low_flag_set);
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("flag set lost"); // R3

	property p_rd_quiet;
		!rd_valid_ff |-> rd_data_ff == 8'h00;
	endproperty
	a_rd_quiet: assert property (p_rd_quiet) else $error("read data without read"); // R9

	property p_bit_no_ext;
		req.valid && (req.op == OP_SET_IO_BIT || req.op == OP_CLR_IO_BIT) && ext_flag_set == '0
			|=> ext_regs_ff == $past(ext_regs_ff);
	endproperty
	a_bit_no_ext: assert property (p_bit_no_ext) else $error("bit op reached extended space"); // R8

	property p_load_answer;
		req.valid && req.op == OP_DATA_LOAD |=> rd_valid_ff && !refuse_ff;
	endproperty
	a_load_answer: assert property (p_load_answer) else $error("data load not answered"); // R7

endmodule

// File: test/iosd_core_model.sv
// CPU core model: issues one request at a time to the I/O decoder.
// Assumes it shares sys_clk with the decoder and is called from the bench.
`timescale 1ns/10ps
module iosd_core_model
	import iosd_pkg::*;
(
	// Clock
	input wire logic sys_clk,
	// Request to the decoder
	output iosd_req_t req
);
	initial begin
		req = '0;
	end
	// Held for one taking edge; callers keep unused bits zero
	// and leave unmapped places alone unless a refusal or a zero read is wanted
	task automatic issue(input iosd_op_t op, input logic [7:0] addr,
		input logic [2:0] b, input logic [7:0] wd);
		@(posedge sys_clk);
		req <= '{1'b1, op, addr, b, wd};
		@(posedge sys_clk);
		req.valid <= 1'b0;
		#1;
	endtask
endmodule

// File: test/io_space_address_decode_test.sv
// Self-checking bench for the I/O space decoder.
// Assumes one 20 MHz clock and the core model as request source.
`timescale 1ns/10ps
module io_space_address_decode_test;
	import iosd_pkg::*;
	logic sys_clk;
	logic rst_b;
	logic [7:0] low_flag_set;
	logic [N_EXT-1:0][7:0] ext_flag_set;
	iosd_req_t req;
	logic [7:0] rd_data_ff;
	logic rd_valid_ff;
	logic refuse_ff;
	logic [7:0] low_flags_ff;
	logic [N_EXT-1:0][7:0] ext_regs_ff;
	int bad_count;
	int comparisons;
	logic [7:0] a;
	logic [7:0] d;
	logic [7:0] seen;
	logic [2:0] b;
	iosd_core_model m(.sys_clk(sys_clk), .req(req));
	iosd_decode dut(.sys_clk(sys_clk), .rst_b(rst_b), .req(req), .low_flag_set(low_flag_set),
		.ext_flag_set(ext_flag_set), .rd_data_ff(rd_data_ff), .rd_valid_ff(rd_valid_ff),
		.refuse_ff(refuse_ff), .low_flags_ff(low_flags_ff), .ext_regs_ff(ext_regs_ff));
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	task automatic chk(input string what, input logic [7:0] s, input logic [7:0] e);
		comparisons++;
		if (s !== e) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", what, e, s);
		end
	endtask
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic load(input iosd_op_t op, input logic [7:0] ad);
		m.issue(op, ad, 3'h0, 8'h00);
		chk("rd_valid", {7'h00, rd_valid_ff}, 8'h01);
		seen = rd_data_ff;
	endtask
	function automatic logic [7:0] exp_bit(input logic [7:0] v, input logic [2:0] k, input logic s);
		exp_bit = v;
		exp_bit[k] = s;
	endfunction
	function automatic logic [7:0] exp_w1c(input logic [7:0] v, input logic [7:0] w);
		return v & ~w;
	endfunction
	initial begin
		rst_b = 1'b0;
		low_flag_set = 8'h00;
		ext_flag_set = '0;
		bad_count = 0;
		comparisons = 0;
		void'($urandom(80581));
		repeat (6) @(posedge sys_clk);
		rst_b <= 1'b1;
		#1;
		chk("flags reset", low_flags_ff, 8'h00);
		for (int i = 0; i < 24; i++) begin
			a = 8'($urandom_range(0, 63));
			d = 8'($urandom);
			b = 3'($urandom);
			if (a == 8'h1c) a = 8'h1d;
			m.issue(OP_OUT, a, 3'h0, d);
			load(OP_DATA_LOAD, a + IO_SPACE_OFFSET);
			chk("data view", seen, d);
			m.issue(iosd_op_t'(OP_SET_IO_BIT + (i % 2)), a, b, 8'h00);
			chk("bit range refuse", {7'h00, refuse_ff}, {7'h00, a > BIT_OP_MAX});
			load(OP_IN, a);
			chk("bit op", seen, (a <= BIT_OP_MAX) ? exp_bit(d, b, ~i[0]) : d);
		end
		@(posedge sys_clk);
		low_flag_set <= 8'hff;
		ext_flag_set[EXT_UART_A] <= 8'hff;
		@(posedge sys_clk);
		low_flag_set <= 8'h00;
		ext_flag_set <= '0;
		load(OP_DATA_LOAD, 8'hc0);
		chk("ext flag", seen, 8'h40);
		m.issue(OP_DATA_STORE, 8'h3c, 3'h0, 8'h05);
		chk("flag w1c", low_flags_ff, exp_w1c(8'hff, 8'h05));
		m.issue(OP_SET_IO_BIT, 8'h1c, 3'h3, 8'h00);
		chk("flag set bit", low_flags_ff, exp_w1c(8'hfa, 8'h08));
		m.issue(OP_CLR_IO_BIT, 8'h1c, 3'h1, 8'h00);
		chk("flag clr bit", low_flags_ff, 8'hf2);
		m.issue(OP_SET_IO_BIT, 8'h20, 3'h0, 8'h00);
		chk("bit refuse", {7'h00, refuse_ff}, 8'h01);
		m.issue(OP_DATA_STORE, 8'hb9, 3'h0, 8'hff);
		chk("ext store", ext_regs_ff[EXT_SHIFT_STATUS], 8'h1f);
		m.issue(OP_DATA_STORE, 8'hc3, 3'h0, 8'h55);
		chk("reserved refuse", {7'h00, refuse_ff}, 8'h01);
		load(OP_DATA_LOAD, 8'hc3);
		chk("reserved read", seen, 8'h00);
		load(OP_DATA_LOAD, 8'hb9);
		chk("ext load", seen, 8'h1f);
		test_done();
	end
	initial begin
		#200000;
		bad_count++;
		test_done();
	end
endmodule
